// ==== bench/dcrm_checker.sv ====
// concurrent checks on the register bank ports
module dcrm_checker import dcrm_pkg::*; (
    input logic ref_clk,
    input logic rst,
    input logic req_valid,
    input logic [7:0] req_slave_addr,
    input logic req_write,
    input logic [15:0] req_reg,
    input logic [15:0] req_wdata,
    input logic rsp_valid,
    input logic rsp_error,
    input logic [15:0] rsp_rdata,
    input logic [7:0] station_address,
    input logic [dcrm_pkg::FUNC_SEL_WIDTH-1:0] output1_function_select,
    input logic [dcrm_pkg::OUT_WIDTH-1:0] core_output_level,
    input logic [dcrm_pkg::OUT_WIDTH-1:0] output_terminal,
    input logic [15:0] speed_setpoint,
    input logic [15:0] voltage_ratio_gain
);
    timeunit 1ns;
    timeprecision 100ps;
    // ====================================================================
    // message classes
    logic ind;
    logic gw;
    logic gok;
    // individual message to this station, gain write, gain in range
    assign ind = req_valid && req_slave_addr == station_address
        && station_address >= SLAVE_ADDR_MIN && station_address <= SLAVE_ADDR_MAX;
    assign gw = req_write && req_reg == REG_VOLTAGE_RATIO_GAIN;
    assign gok = req_wdata >= GAIN_MIN && req_wdata <= GAIN_MAX;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ====================================================================
    // properties
    property p_rsp_ind;
        ind |=> rsp_valid;
    endproperty
    a_rsp_ind: assert property (p_rsp_ind) else $error("no answer to message");
    property p_rsp_only_ind;
        rsp_valid |-> $past(ind);
    endproperty
    a_rsp_only_ind: assert property (p_rsp_only_ind) else $error("stray answer");
    property p_gain_range;
        voltage_ratio_gain >= GAIN_MIN && voltage_ratio_gain <= GAIN_MAX;
    endproperty
    a_gain_range: assert property (p_gain_range) else $error("gain out of range");
    property p_gain_reject;
        ind && gw && !gok |=> rsp_error && $stable(voltage_ratio_gain);
    endproperty
    a_gain_reject: assert property (p_gain_reject) else $error("bad gain taken");
    property p_gain_accept;
        ind && gw && gok |=> !rsp_error && voltage_ratio_gain == $past(req_wdata);
    endproperty
    a_gain_accept: assert property (p_gain_accept) else $error("gain not stored");
    property p_cmd_mask;
        ind && !req_write && req_reg == REG_DRIVE_COMMAND_WORD |=> rsp_rdata[15:11] == 5'h00;
    endproperty
    a_cmd_mask: assert property (p_cmd_mask) else $error("unused bits set");
    property p_bcast_gain;
        req_valid && req_slave_addr == BCAST_ADDR && gw |=> $stable(voltage_ratio_gain);
    endproperty
    a_bcast_gain: assert property (p_bcast_gain) else $error("broadcast gain taken");
    property p_out_local;
        output1_function_select != FUNC_COMM_OUTPUT |=>
            output_terminal[0] == $past(core_output_level[0]);
    endproperty
    a_out_local: assert property (p_out_local) else $error("output not local");
    property p_setpoint;
        ind && req_write && req_reg == REG_SPEED_SETPOINT |=> speed_setpoint == $past(req_wdata);
    endproperty
    a_setpoint: assert property (p_setpoint) else $error("setpoint not stored");
endmodule

bind dcrm_regbank dcrm_checker chk_u (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid),
    .req_slave_addr(req_slave_addr), .req_write(req_write), .req_reg(req_reg),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_error(rsp_error),
    .rsp_rdata(rsp_rdata), .station_address(station_address),
    .output1_function_select(output1_function_select),
    .core_output_level(core_output_level), .output_terminal(output_terminal),
    .speed_setpoint(speed_setpoint), .voltage_ratio_gain(voltage_ratio_gain));

// ==== bench/dcrm_master.sv ====
// link master model issuing decoded messages
module dcrm_master (
    input logic ref_clk,
    output logic req_valid,
    output logic [7:0] req_slave_addr,
    output logic req_write,
    output logic [15:0] req_reg,
    output logic [15:0] req_wdata,
    input logic rsp_valid,
    input logic rsp_error,
    input logic [15:0] rsp_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle lines at time zero
    initial begin
        req_valid = 1'b0;
        {req_slave_addr, req_write, req_reg, req_wdata} = '0;
    end
    // one message of 16-bit words; released lines show the inverse
    task automatic xfer(input logic [7:0] a, input logic w, input logic [15:0] r, d,
        output logic v, e, output logic [15:0] q);
        @(posedge ref_clk);
        req_valid <= 1'b1;
        req_slave_addr <= a;
        req_write <= w;
        req_reg <= r;
        req_wdata <= d;
        @(posedge ref_clk);
        req_valid <= 1'b0;
        {req_slave_addr, req_write, req_reg, req_wdata} <= ~{a, w, r, d};
        #1;
        v = rsp_valid;
        e = rsp_error;
        q = rsp_rdata;
    endtask
endmodule

// ==== bench/dcrm_regbank_bench.sv ====
// self-checking bench for the register bank
module dcrm_regbank_bench import dcrm_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk, rst, req_valid, req_write, rsp_valid, rsp_error, vec, v, e;
    logic t_run, t_rev, t_trip, t_frst, run, rev, trip, frst;
    logic [7:0] req_slave_addr, sta, sel1, sel2, sel3;
    logic [15:0] req_reg, req_wdata, rsp_rdata, mfreq, mon, sp, gain, q;
    logic [6:0] t_mf, mf;
    logic [2:0] core, outp;
    int err_total, compares;
    logic [15:0] gv [4] = '{16'h0014, 16'h07d0, 16'h0013, 16'h07d1};
    logic [15:0] mr [18] = '{16'h20, 16'h21, 16'h23, 16'h24, 16'h27, 16'h28, 16'h29,
        16'h2a, 16'h2c, 16'h2e, 16'h31, 16'h32, 16'h35, 16'h37, 16'h38, 16'h39, 16'h3a, 16'h3d};
    // ====================================================================
    // design and master
    dcrm_master m_u (.ref_clk(ref_clk), .req_valid(req_valid), .req_slave_addr(req_slave_addr),
        .req_write(req_write), .req_reg(req_reg), .req_wdata(req_wdata),
        .rsp_valid(rsp_valid), .rsp_error(rsp_error), .rsp_rdata(rsp_rdata));
    dcrm_regbank dut_u (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid),
        .req_slave_addr(req_slave_addr), .req_write(req_write), .req_reg(req_reg),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_error(rsp_error),
        .rsp_rdata(rsp_rdata), .station_address(sta), .max_freq_in_unit(mfreq),
        .output1_function_select(sel1), .output2_function_select(sel2),
        .output3_function_select(sel3), .vector_control_mode(vec), .term_run(t_run),
        .term_reverse(t_rev), .term_ext_trip(t_trip), .term_fault_reset(t_frst),
        .term_mf_input(t_mf), .core_output_level(core),
        .mon_run_state_flags(mon ^ 16'h20), .mon_trip_flags_primary(mon ^ 16'h21),
        .mon_setpoint(mon ^ 16'h23), .mon_actual_speed(mon ^ 16'h24),
        .mon_load_current(mon ^ 16'h27), .mon_load_voltage(mon ^ 16'h28),
        .mon_trip_flags_secondary(mon ^ 16'h29), .mon_alarm_flags(mon ^ 16'h2a),
        .mon_drive_state_primary(mon ^ 16'h2c), .mon_drive_state_secondary(mon ^ 16'h2e),
        .mon_dc_bus_voltage(mon ^ 16'h31), .mon_torque(mon ^ 16'h32),
        .mon_run_hours(mon ^ 16'h35), .mon_load_power(mon ^ 16'h37),
        .mon_loop_feedback(mon ^ 16'h38), .mon_loop_input(mon ^ 16'h39),
        .mon_loop_output(mon ^ 16'h3a), .mon_link_error_flags(mon ^ 16'h3d),
        .drive_run(run), .drive_reverse(rev), .link_external_trip(trip),
        .drive_fault_reset(frst), .drive_mf_input(mf), .speed_setpoint(sp),
        .voltage_ratio_gain(gain), .output_terminal(outp));
    // ====================================================================
    // tasks
    task automatic chk(input string n, input logic [15:0] s, x);
        compares++;
        if (s !== x) begin
            err_total++;
            $display("BAD %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic wr(input logic [15:0] r, d, input logic xe);
        m_u.xfer(8'h05, 1'b1, r, d, v, e, q);
        chk("wr_valid", 16'(v), 16'h1);
        chk("wr_error", 16'(e), 16'(xe));
    endtask
    task automatic rd(input logic [15:0] r, x, input logic xe);
        m_u.xfer(8'h05, 1'b0, r, 16'h0, v, e, q);
        chk("rd_error", 16'(e), 16'(xe));
        chk("rd_data", q, x);
    endtask
    task automatic quiet(input logic [7:0] a, input logic [15:0] r, d);
        m_u.xfer(a, 1'b1, r, d, v, e, q);
        chk("no_answer", 16'(v), 16'h0);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic conclude();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ====================================================================
    // clock and watchdog
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        conclude();
    end
    // ====================================================================
    // test sequence
    initial begin
        {err_total, compares} = '0;
        {rst, sta, mfreq, mon} = {1'b1, 8'h05, 16'h1770, 16'h8a5c};
        {sel1, sel2, sel3, core, vec} = {8'h12, 8'h00, 8'h12, 3'h2, 1'b0};
        {t_run, t_rev, t_trip, t_frst, t_mf} = '0;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        chk("gain_reset", gain, GAIN_UNITY);
        wr(REG_DRIVE_COMMAND_WORD, 16'hffff, 1'b0);
        rd(REG_DRIVE_COMMAND_WORD, CMD_VALID_MASK, 1'b0);
        chk("mf_out", 16'(mf), 16'h007f);
        wr(REG_DRIVE_COMMAND_WORD, 16'h0005, 1'b0);
        settle(1);
        chk("cmd_out", 16'({frst, trip, rev, run}), 16'h0005);
        @(posedge ref_clk) {t_rev, t_mf} <= {1'b1, 7'h2a};
        settle(4);
        chk("cmd_or", 16'({frst, trip, rev, run}), 16'h0007);
        rd(REG_DRIVE_COMMAND_WORD, 16'h0005, 1'b0);
        rd(REG_INPUT_PIN_STATE, 16'h002a, 1'b0);
        for (int i = 0; i < 4; i++) begin
            wr(REG_VOLTAGE_RATIO_GAIN, gv[i], i > 1);
            rd(REG_VOLTAGE_RATIO_GAIN, (i > 1) ? 16'h07d0 : gv[i], 1'b0);
        end
        rd(REG_LINK_WRITE_FLAGS, 16'h0008, 1'b0);
        wr(16'h0020, 16'h1234, 1'b1);
        rd(16'h0025, 16'h0000, 1'b1);
        quiet(8'h06, REG_SPEED_SETPOINT, 16'h1111);
        @(posedge ref_clk) sta <= 8'h21;
        quiet(8'h21, REG_SPEED_SETPOINT, 16'h2222);
        @(posedge ref_clk) sta <= 8'h05;
        wr(REG_SPEED_SETPOINT, 16'h1770, 1'b0);
        chk("setpoint", sp, 16'h1770);
        wr(REG_DRIVE_COMMAND_WORD, 16'h0070, 1'b0);
        quiet(BCAST_ADDR, REG_DRIVE_COMMAND_WORD, 16'hffff);
        rd(REG_DRIVE_COMMAND_WORD, 16'h007f, 1'b0);
        quiet(BCAST_ADDR, REG_VOLTAGE_RATIO_GAIN, 16'h0100);
        rd(REG_VOLTAGE_RATIO_GAIN, 16'h07d0, 1'b0);
        quiet(BCAST_ADDR, REG_SPEED_SETPOINT, BCAST_HALF_SCALE);
        rd(REG_SPEED_SETPOINT, 16'h0bb8, 1'b0);
        wr(REG_LINK_OUTPUT_CONTROL, 16'h0005, 1'b0);
        settle(2);
        chk("outputs", 16'(outp), 16'h0007);
        rd(REG_OUTPUT_PIN_STATE, 16'h0007, 1'b0);
        wr(REG_LINK_OUTPUT_CONTROL, 16'h0000, 1'b0);
        @(posedge ref_clk) {sel1, core} <= {8'h00, 3'h1};
        settle(3);
        chk("outputs", 16'(outp), 16'h0001);
        for (int i = 0; i < 18; i++) begin
            rd(mr[i], mon ^ mr[i], 1'b0);
        end
        @(posedge ref_clk) vec <= 1'b1;
        rd(REG_LOAD_POWER_READBACK, 16'h0000, 1'b1);
        conclude();
    end
endmodule

// ==== core/dcrm_bcast_scale.sv ====
// converts a broadcast setpoint on the 30000 scale into the selected unit
module dcrm_bcast_scale (
    dcrm_scale_if.scaler sif
);
    import dcrm_pkg::*;

    logic [32:0] prod;
    logic [32:0] quo;

    // ====================================================================
    // rounded value * fmax / 30000, saturated to one word
    always_comb begin
        prod = 33'(sif.raw) * 33'(sif.fmax) + 33'(BCAST_HALF_SCALE);
        quo = prod / 33'(BCAST_FULL_SCALE);
        sif.scaled = (quo > 33'h0ffff) ? 16'hffff : quo[15:0];
    end
endmodule

// ==== core/dcrm_out_select.sv ====
// steers one output terminal to the link bit or to its own function
module dcrm_out_select #(
    parameter int FUNC_W = 8
) (
    input logic [FUNC_W-1:0] func_sel,
    input logic link_bit,
    input logic local_bit,
    output logic drive
);
    import dcrm_pkg::*;

    // the link owns the terminal only in communications output mode
    assign drive = (func_sel == FUNC_W'(FUNC_COMM_OUTPUT)) ? link_bit : local_bit;
endmodule

// ==== core/dcrm_pkg.sv ====
// constants and register map of the drive command register bank
// ====================================================================
package dcrm_pkg;

    // ====================================================================
    // addressing
    localparam logic [7:0] BCAST_ADDR = 8'h00;
    localparam logic [7:0] SLAVE_ADDR_MIN = 8'h01;
    localparam logic [7:0] SLAVE_ADDR_MAX = 8'h20;
    localparam logic [15:0] CMD_SPACE_LAST = 16'h000f;

    // ====================================================================
    // register numbers
    localparam logic [15:0] REG_DRIVE_COMMAND_WORD = 16'h0001;
    localparam logic [15:0] REG_SPEED_SETPOINT = 16'h0002;
    localparam logic [15:0] REG_VOLTAGE_RATIO_GAIN = 16'h0003;
    localparam logic [15:0] REG_LINK_OUTPUT_CONTROL = 16'h0009;
    localparam logic [15:0] REG_RUN_STATE_FLAGS = 16'h0020;
    localparam logic [15:0] REG_TRIP_FLAGS_PRIMARY = 16'h0021;
    localparam logic [15:0] REG_LINK_WRITE_FLAGS = 16'h0022;
    localparam logic [15:0] REG_SETPOINT_READBACK = 16'h0023;
    localparam logic [15:0] REG_ACTUAL_SPEED_READBACK = 16'h0024;
    localparam logic [15:0] REG_LOAD_CURRENT_READBACK = 16'h0027;
    localparam logic [15:0] REG_LOAD_VOLTAGE_READBACK = 16'h0028;
    localparam logic [15:0] REG_TRIP_FLAGS_SECONDARY = 16'h0029;
    localparam logic [15:0] REG_ALARM_FLAGS = 16'h002a;
    localparam logic [15:0] REG_INPUT_PIN_STATE = 16'h002b;
    localparam logic [15:0] REG_DRIVE_STATE_PRIMARY = 16'h002c;
    localparam logic [15:0] REG_OUTPUT_PIN_STATE = 16'h002d;
    localparam logic [15:0] REG_DRIVE_STATE_SECONDARY = 16'h002e;
    localparam logic [15:0] REG_DC_BUS_VOLTAGE_READBACK = 16'h0031;
    localparam logic [15:0] REG_TORQUE_READBACK = 16'h0032;
    localparam logic [15:0] REG_RUN_HOURS_COUNTER = 16'h0035;
    localparam logic [15:0] REG_LOAD_POWER_READBACK = 16'h0037;
    localparam logic [15:0] REG_LOOP_FEEDBACK_READBACK = 16'h0038;
    localparam logic [15:0] REG_LOOP_INPUT_READBACK = 16'h0039;
    localparam logic [15:0] REG_LOOP_OUTPUT_READBACK = 16'h003a;
    localparam logic [15:0] REG_LINK_ERROR_FLAGS = 16'h003d;

    // ====================================================================
    // field layout
    localparam int CMD_RUN_BIT = 0;
    localparam int CMD_REVERSE_BIT = 1;
    localparam int CMD_EXT_TRIP_BIT = 2;
    localparam int CMD_FAULT_RESET_BIT = 3;
    localparam int CMD_MF_LSB = 4;
    localparam int CMD_MF_WIDTH = 7;
    localparam logic [15:0] CMD_VALID_MASK = 16'h07ff;
    localparam logic [15:0] CMD_BCAST_MASK = 16'h000f;
    localparam int OUT_WIDTH = 3;
    localparam int LWF_WRITING_BIT = 0;
    localparam int LWF_LIMIT_ERR_BIT = 3;

    // ====================================================================
    // reset values and limits
    localparam logic [15:0] CMD_RESET = 16'h0000;
    localparam logic [15:0] SETPOINT_RESET = 16'h0000;
    localparam logic [15:0] GAIN_UNITY = 16'h03e8;
    localparam logic [15:0] GAIN_MIN = 16'h0014;
    localparam logic [15:0] GAIN_MAX = 16'h07d0;
    localparam logic [2:0] OUT_RESET = 3'h0;
    localparam logic [15:0] BCAST_FULL_SCALE = 16'h7530;
    localparam logic [15:0] BCAST_HALF_SCALE = 16'h3a98;
    localparam logic [7:0] FUNC_COMM_OUTPUT = 8'h12;
    localparam int FUNC_SEL_WIDTH = 8;

endpackage

// ==== core/dcrm_regbank.sv ====
// drive command register bank behind the multi-drop link message decoder
module dcrm_regbank #(
    parameter int EXTENDED_MONITORS = 1
) (
    input logic ref_clk,
    input logic rst,
    // decoded link message
    input logic req_valid,
    input logic [7:0] req_slave_addr,
    input logic req_write,
    input logic [15:0] req_reg,
    input logic [15:0] req_wdata,
    output logic rsp_valid,
    output logic rsp_error,
    output logic [15:0] rsp_rdata,
    // configuration from the parameter store
    input logic [7:0] station_address,
    input logic [15:0] max_freq_in_unit,
    input logic [dcrm_pkg::FUNC_SEL_WIDTH-1:0] output1_function_select,
    input logic [dcrm_pkg::FUNC_SEL_WIDTH-1:0] output2_function_select,
    input logic [dcrm_pkg::FUNC_SEL_WIDTH-1:0] output3_function_select,
    input logic vector_control_mode,
    // control terminals, asynchronous pins
    input logic term_run,
    input logic term_reverse,
    input logic term_ext_trip,
    input logic term_fault_reset,
    input logic [dcrm_pkg::CMD_MF_WIDTH-1:0] term_mf_input,
    // own output functions of the drive core
    input logic [dcrm_pkg::OUT_WIDTH-1:0] core_output_level,
    // monitors from the drive core, same clock
    input logic [15:0] mon_run_state_flags,
    input logic [15:0] mon_trip_flags_primary,
    input logic [15:0] mon_setpoint,
    input logic [15:0] mon_actual_speed,
    input logic [15:0] mon_load_current,
    input logic [15:0] mon_load_voltage,
    input logic [15:0] mon_trip_flags_secondary,
    input logic [15:0] mon_alarm_flags,
    input logic [15:0] mon_drive_state_primary,
    input logic [15:0] mon_drive_state_secondary,
    input logic [15:0] mon_dc_bus_voltage,
    input logic [15:0] mon_torque,
    input logic [15:0] mon_run_hours,
    input logic [15:0] mon_load_power,
    input logic [15:0] mon_loop_feedback,
    input logic [15:0] mon_loop_input,
    input logic [15:0] mon_loop_output,
    input logic [15:0] mon_link_error_flags,
    // commands to the drive core
    output logic drive_run,
    output logic drive_reverse,
    output logic link_external_trip,
    output logic drive_fault_reset,
    output logic [dcrm_pkg::CMD_MF_WIDTH-1:0] drive_mf_input,
    output logic [15:0] speed_setpoint,
    output logic [15:0] voltage_ratio_gain,
    output logic [dcrm_pkg::OUT_WIDTH-1:0] output_terminal
);
    import dcrm_pkg::*;

    // command bits plus inputs
    localparam int TERM_W = 4 + CMD_MF_WIDTH;

    // ====================================================================
    // elaboration checks
    if (EXTENDED_MONITORS != 0 && EXTENDED_MONITORS != 1) begin : g_bad_variant
        $error("EXTENDED_MONITORS must be 0 or 1");
    end

    // bank state, one word
    typedef struct packed {
        // link words
        logic [15:0] cmd;
        logic [15:0] setp;
        logic [15:0] gain;
        logic [OUT_WIDTH-1:0] outw;

        // status flags
        logic limit_err;
        logic writing;

        // pin and drive stages
        logic [TERM_W-1:0] term_meta;
        logic [TERM_W-1:0] term_sync;
        logic [OUT_WIDTH-1:0] pins;
        logic [TERM_W-1:0] drv;

        // answer
        logic rsp_valid;
        logic rsp_error;
        logic [15:0] rsp_rdata;
    } dcrm_state_t;

    dcrm_state_t st;
    dcrm_state_t next_st;

    // scaler and selector wiring
    dcrm_scale_if sif ();
    logic [OUT_WIDTH-1:0] sel_drive;
    logic [FUNC_SEL_WIDTH-1:0] func_sel [OUT_WIDTH];

    // ====================================================================
    // broadcast setpoint scaler
    assign sif.raw = req_wdata;
    assign sif.fmax = max_freq_in_unit;

    dcrm_bcast_scale u_scale (
        .sif(sif.scaler)
    );

    // ====================================================================
    // output terminal steering, one selector per terminal
    assign func_sel[0] = output1_function_select;
    assign func_sel[1] = output2_function_select;
    assign func_sel[2] = output3_function_select;

    for (genvar i = 0; i < OUT_WIDTH; i++) begin : g_out
        dcrm_out_select #(
            .FUNC_W(FUNC_SEL_WIDTH)
        ) u_sel (
            .func_sel(func_sel[i]),
            .link_bit(st.outw[i]),
            .local_bit(core_output_level[i]),
            .drive(sel_drive[i])
        );
    end

    // ====================================================================
    // read multiplexer, one word per register number
    function automatic logic [16:0] read_word(input logic [15:0] regn);
        logic [15:0] d;
        logic ok;
        d = 16'h0000;
        ok = 1'b1;
        case (regn)
            REG_DRIVE_COMMAND_WORD: d = st.cmd & CMD_VALID_MASK;
            REG_SPEED_SETPOINT: d = st.setp;
            REG_VOLTAGE_RATIO_GAIN: d = st.gain;
            REG_LINK_OUTPUT_CONTROL: d = {13'h0000, st.outw};
            // live monitor words, plus the bank's link write flags and registered pin states
            REG_RUN_STATE_FLAGS: d = mon_run_state_flags;
            REG_TRIP_FLAGS_PRIMARY: d = mon_trip_flags_primary;
            REG_LINK_WRITE_FLAGS: begin
                d[LWF_WRITING_BIT] = st.writing;
                d[LWF_LIMIT_ERR_BIT] = st.limit_err;
            end
            REG_SETPOINT_READBACK: d = mon_setpoint;
            REG_ACTUAL_SPEED_READBACK: d = mon_actual_speed;
            REG_LOAD_CURRENT_READBACK: d = mon_load_current;
            REG_LOAD_VOLTAGE_READBACK: d = mon_load_voltage;

            REG_TRIP_FLAGS_SECONDARY: begin
                d = mon_trip_flags_secondary;
                ok = (EXTENDED_MONITORS == 1);
            end
            REG_ALARM_FLAGS: begin
                d = mon_alarm_flags;
                ok = (EXTENDED_MONITORS == 1);
            end

            REG_INPUT_PIN_STATE: d = {9'h000, st.term_sync[TERM_W-1:4]};
            REG_DRIVE_STATE_PRIMARY: d = mon_drive_state_primary;
            REG_OUTPUT_PIN_STATE: d = {13'h0000, st.pins};
            REG_DRIVE_STATE_SECONDARY: begin
                d = mon_drive_state_secondary;
                ok = (EXTENDED_MONITORS == 1);
            end

            REG_DC_BUS_VOLTAGE_READBACK: d = mon_dc_bus_voltage;
            REG_TORQUE_READBACK: d = mon_torque;
            REG_RUN_HOURS_COUNTER: begin
                d = mon_run_hours;
                ok = (EXTENDED_MONITORS == 1);
            end
            REG_LOAD_POWER_READBACK: begin
                d = vector_control_mode ? 16'h0000 : mon_load_power;
                ok = !vector_control_mode;
            end

            REG_LOOP_FEEDBACK_READBACK: d = mon_loop_feedback;
            REG_LOOP_INPUT_READBACK: d = mon_loop_input;
            REG_LOOP_OUTPUT_READBACK: d = mon_loop_output;
            REG_LINK_ERROR_FLAGS: d = mon_link_error_flags;
            default: ok = 1'b0;
        endcase
        // refused: zero word
        if (!ok) begin
            d = 16'h0000;
        end
        return {ok, d};
    endfunction

    // ====================================================================
    // next state
    always_comb begin
        logic individual;
        logic bcast;
        logic cmd_space;
        logic [16:0] rd;
        logic [TERM_W-1:0] link_cmd;
        individual = 1'b0;
        bcast = 1'b0;
        cmd_space = 1'b0;
        rd = 17'h00000;
        link_cmd = '0;

        // default: hold, no answer
        next_st = st;
        next_st.rsp_valid = 1'b0;
        next_st.rsp_error = 1'b0;
        next_st.writing = 1'b0;

        // terminal pins pass two flops before use
        next_st.term_meta = {term_mf_input, term_fault_reset, term_ext_trip,
                             term_reverse, term_run};
        next_st.term_sync = st.term_meta;

        // own station must itself be a legal individual address
        individual = req_valid && (req_slave_addr == station_address)
                     && (station_address >= SLAVE_ADDR_MIN)
                     && (station_address <= SLAVE_ADDR_MAX);

        bcast = req_valid && req_write && (req_slave_addr == BCAST_ADDR);
        cmd_space = (req_reg <= CMD_SPACE_LAST);

        if (individual) begin
            next_st.rsp_valid = 1'b1;
            if (req_write) begin
                next_st.writing = 1'b1;
                next_st.rsp_rdata = 16'h0000;
                case (req_reg)
                    REG_DRIVE_COMMAND_WORD: begin
                        next_st.cmd = req_wdata & CMD_VALID_MASK;
                        next_st.limit_err = 1'b0;
                    end

                    REG_SPEED_SETPOINT: begin
                        next_st.setp = req_wdata;
                        next_st.limit_err = 1'b0;
                    end

                    REG_VOLTAGE_RATIO_GAIN: begin
                        if (req_wdata >= GAIN_MIN && req_wdata <= GAIN_MAX) begin
                            next_st.gain = req_wdata;
                            next_st.limit_err = 1'b0;
                        end else begin
                            next_st.limit_err = 1'b1;
                            next_st.rsp_error = 1'b1;
                            next_st.writing = 1'b0;
                        end
                    end

                    REG_LINK_OUTPUT_CONTROL: begin
                        next_st.outw = req_wdata[OUT_WIDTH-1:0];
                        next_st.limit_err = 1'b0;
                    end

                    default: begin
                        next_st.rsp_error = 1'b1;
                        next_st.writing = 1'b0;
                    end
                endcase

                if (!cmd_space) begin
                    next_st.rsp_error = 1'b1;
                end
            end else begin
                // reads store nothing
                rd = read_word(req_reg);
                next_st.rsp_rdata = rd[15:0];
                next_st.rsp_error = !rd[16];
            end
        end else if (bcast) begin
            // broadcast is never answered
            case (req_reg)
                REG_DRIVE_COMMAND_WORD: begin
                    next_st.writing = 1'b1;
                    next_st.cmd = (st.cmd & ~CMD_BCAST_MASK)
                                  | (req_wdata & CMD_BCAST_MASK);
                end

                REG_SPEED_SETPOINT: begin
                    next_st.writing = 1'b1;
                    next_st.setp = sif.scaled;
                end

                default: next_st.writing = 1'b0;
            endcase
        end

        // link commands ORed with terminals
        link_cmd = {st.cmd[CMD_MF_LSB +: CMD_MF_WIDTH], st.cmd[CMD_FAULT_RESET_BIT],
                    st.cmd[CMD_EXT_TRIP_BIT], st.cmd[CMD_REVERSE_BIT],
                    st.cmd[CMD_RUN_BIT]};
        next_st.drv = link_cmd | st.term_sync;

        // pins lag selectors one edge
        next_st.pins = sel_drive;
    end

    // ====================================================================
    // state register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st.cmd <= CMD_RESET;
            st.setp <= SETPOINT_RESET;
            st.gain <= GAIN_UNITY;
            st.outw <= OUT_RESET;
            st.limit_err <= 1'b0;
            st.writing <= 1'b0;

            st.term_meta <= '0;
            st.term_sync <= '0;
            st.pins <= OUT_RESET;
            st.drv <= '0;

            st.rsp_valid <= 1'b0;
            st.rsp_error <= 1'b0;
            st.rsp_rdata <= 16'h0000;
        end else begin
            st <= next_st;
        end
    end

    // ====================================================================
    // outputs straight from the state register
    assign rsp_valid = st.rsp_valid;
    assign rsp_error = st.rsp_error;
    assign rsp_rdata = st.rsp_rdata;

    // drive core commands
    assign drive_run = st.drv[0];
    assign drive_reverse = st.drv[1];
    assign link_external_trip = st.drv[2];
    assign drive_fault_reset = st.drv[3];
    assign drive_mf_input = st.drv[TERM_W-1:4];

    // stored words, pins
    assign speed_setpoint = st.setp;
    assign voltage_ratio_gain = st.gain;
    assign output_terminal = st.pins;
endmodule

// ==== core/dcrm_scale_if.sv ====
// carrier between the register bank and the broadcast setpoint scaler
interface dcrm_scale_if;
    logic [15:0] raw;
    logic [15:0] fmax;
    logic [15:0] scaled;
    modport user (output raw, output fmax, input scaled);
    modport scaler (input raw, input fmax, output scaled);
endinterface
